// File: rtl/ccd_decoder.sv
/*
 * Control-port instruction decoder: holds framing, timing, receive and transmit
 * byte registers and forwards other register traffic to the codec core.
 * Assumes pins are asynchronous and the control clock is far slower than
 * sys_clk; PCM-side strobes arrive on sys_clk.
 */
// Overview of operation
// [RL1] Register writes use two bytes: address/command byte then data byte.
// [RL2] Address bit 7 set powers down, clear powers up, on every instruction.
// [RL3] Address bit 1 announces a data byte; clear means single-byte power command.
// [RL4] Address bit 2 selects write (0) or read-back (1) of the second byte.
// [RL5] Bits 6..3 give the index; writes 0..11 and 14, reads 0..11 except 3.
// [RL6] Host leaves the write-only test register alone in normal use.
// [RL7] Index 2 write feeds receive path, read returns last PCM byte; 3 transmit-only.
// [RL8] Indices 12, 13 and 15 are never written nor read back.
// [RL9] Both bytes travel MSB first on command input and reply output.
// [RL10] Host writes zero into every reserved bit.
// [RL11] Framing bits 7:6 give the PCM bit clock rate, default 512 kHz.
// [RL12] Framing bit 5 picks linear or companded; bits 4:3 pick linear format.
// [RL13] In companded mode bits 4:3 pick mu-law or A-law variants.
// [RL14] Framing bit 2 separates voice slots by two bits, companded only.
// [RL15] Framing bit 1 picks 7-bit slot in companded mode; bit 0 loop-back.
// [RL16] Timing bits 7:6 give frame-sync relation: delayed, normal, reverse.
// [RL17] Timing bit 5 drives the output latch inverted.
// [RL18] Companded: timing bit 4 feeds receive path from the written byte.
// [RL19] Companded: timing bit 3 sources transmit line from the written byte.
// [RL20] Timing bit 2 enables voice transfer on both PCM lines.
// [RL21] Companded: timing bit 1 picks second channel; bit 0 reserved.
// [RL22] Eight control clocks per byte; input sampled on rising edges.
// [RL23] Read-back shifts out on falling edges over eight further clocks.
// [RL24] Second byte may share or follow chip select; loaded at its end.
// [RL25] Reply output is released whenever chip select is high.
// [RL26] Framing and timing registers reset to all zeros.
`timescale 1ns/1ps
module ccd_decoder
  import ccd_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       ctrl_shift_clock_i,
  input  wire logic       serial_cmd_in_i,
  output logic            serial_reply_out_o,
  output logic            serial_reply_out_oe_o,
  output logic            power_down_o,
  output logic      [1:0] clock_rate_o,
  output logic            companding_sel_o,
  output logic      [1:0] format_sel_o,
  output logic            slot_spacing_sel_o,
  output logic            slot_width_sel_o,
  output logic            loopback_sel_o,
  output logic      [1:0] frame_timing_o,
  output logic            output_latch_o,
  output logic            rx_source_sel_o,
  output logic            tx_source_sel_o,
  output logic            voice_enable_o,
  output logic            channel_pick_o,
  input  wire logic       rx_pcm_valid_i,
  input  wire logic [7:0] rx_pcm_byte_i,
  output logic            rx_path_stb_o,
  output logic      [7:0] rx_path_byte_o,
  input  wire logic       tx_path_valid_i,
  input  wire logic [7:0] tx_path_byte_i,
  output logic            tx_line_stb_o,
  output logic      [7:0] tx_line_byte_o,
  output logic            ext_wr_stb_o,
  output logic      [3:0] ext_index_o,
  output logic      [7:0] ext_wr_data_o,
  input  wire logic [7:0] ext_rd_data_i
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic is_writable(input logic [3:0] idx);
    is_writable = (idx <= IDX_LAST_STD) || (idx == IDX_TEST);
  endfunction

  function automatic logic is_readable(input logic [3:0] idx);
    is_readable = (idx <= IDX_LAST_STD) && (idx != IDX_TX_PORT);
  endfunction

  ccd_state_t state_reg;
  logic [2:0] pins_sync;
  logic       sclk_prev_reg;
  logic       cs_active;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [7:0] shift_byte;
  logic       byte_done;
  logic       reply_bit;
  logic [3:0] idx_reg;
  logic [7:0] framing_reg;
  logic [7:0] timing_reg;
  logic [7:0] rx_latest_reg;
  logic [7:0] tx_port_reg;
  logic [7:0] load_byte_reg;
  logic       load_reg;
  logic       cmd_done;
  logic       data_done;
  logic [3:0] cmd_index;

  // ----------------------------------------------------------------------
  // Pin synchronisation and control-clock edge detection
  // ----------------------------------------------------------------------
  ccd_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({cs_n_i, ctrl_shift_clock_i, serial_cmd_in_i}),
    .rst_val_i (PINS_RST),
    .sync_o    (pins_sync)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= pins_sync[1];
    end
  end

  assign cs_active = !pins_sync[2];
  assign sclk_rise = cs_active && pins_sync[1] && !sclk_prev_reg;  // [RL22]
  assign sclk_fall = !pins_sync[1] && sclk_prev_reg;              // [RL23]

  ccd_shifter u_shifter (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .cs_active_i (cs_active),
    .rise_i      (sclk_rise),
    .fall_i      (sclk_fall),
    .data_i      (pins_sync[0]),
    .load_i      (load_reg),
    .load_byte_i (load_byte_reg),
    .byte_o      (shift_byte),
    .byte_done_o (byte_done),
    .reply_bit_o (reply_bit)
  );

  // Released as soon as chip select is seen high, so devices can share it
  assign serial_reply_out_oe_o = cs_active;                     // [RL25]
  assign serial_reply_out_o    = reply_bit;                     // [RL9]

  // ----------------------------------------------------------------------
  // Instruction sequencing
  // ----------------------------------------------------------------------
  assign cmd_done  = byte_done && (state_reg == ST_IDLE);
  assign data_done = byte_done && (state_reg == ST_WRITE);
  assign cmd_index = shift_byte[INDEX_HI:INDEX_LO];             // [RL5]

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (byte_done && shift_byte[FOLLOW_BIT]) begin        // [RL3]
            if (shift_byte[DIR_BIT]) begin                      // [RL4]
              state_reg <= is_readable(cmd_index) ? ST_FETCH : ST_SKIP;
            end else begin
              state_reg <= is_writable(cmd_index) ? ST_WRITE : ST_SKIP;  // [RL8]
            end
          end
        end
        ST_WRITE: begin
          if (byte_done) begin                                  // [RL1] [RL24]
            state_reg <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          state_reg <= ST_READ;
        end
        ST_READ, ST_SKIP: begin
          if (byte_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      idx_reg <= '0;
    end else if (cmd_done) begin
      idx_reg <= cmd_index;
    end
  end

  assign ext_index_o = idx_reg;

  // Every address byte carries the power bit, even with a data byte following
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      power_down_o <= POWER_DOWN_RST;
    end else if (cmd_done) begin
      power_down_o <= shift_byte[POWER_BIT];                    // [RL2]
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      framing_reg <= FRAMING_RST;                               // [RL26]
      timing_reg  <= TIMING_RST;
    end else if (data_done && idx_reg == IDX_FRAMING) begin
      framing_reg <= shift_byte;                                // [RL24]
    end else if (data_done && idx_reg == IDX_TIMING) begin
      timing_reg <= shift_byte;
    end
  end

  assign clock_rate_o       = framing_reg[FR_RATE_LO+1:FR_RATE_LO];  // [RL11]
  assign companding_sel_o   = framing_reg[FR_COMPAND];               // [RL12]
  assign format_sel_o       = framing_reg[FR_FMT_LO+1:FR_FMT_LO];    // [RL12] [RL13]
  assign slot_spacing_sel_o = companding_sel_o && framing_reg[FR_SPACING];  // [RL14]
  assign slot_width_sel_o   = companding_sel_o && framing_reg[FR_WIDTH];    // [RL15]
  assign loopback_sel_o     = framing_reg[FR_LOOPBACK];              // [RL15]
  assign frame_timing_o     = timing_reg[TM_FRAME_LO+1:TM_FRAME_LO]; // [RL16]
  assign output_latch_o     = !timing_reg[TM_LATCH];                 // [RL17]
  assign rx_source_sel_o    = companding_sel_o && timing_reg[TM_RX_SRC];   // [RL18]
  assign tx_source_sel_o    = companding_sel_o && timing_reg[TM_TX_SRC];   // [RL19]
  assign voice_enable_o     = timing_reg[TM_VOICE_EN];               // [RL20]
  assign channel_pick_o     = companding_sel_o && timing_reg[TM_CHANNEL];  // [RL21]

  // ----------------------------------------------------------------------
  // Forwarded writes to the codec core
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ext_wr_stb_o  <= 1'b0;
      ext_wr_data_o <= BYTE_RST;
    end else begin
      ext_wr_stb_o <= data_done && (idx_reg > IDX_TX_PORT);    // [RL5] [RL6]
      if (data_done) begin
        ext_wr_data_o <= shift_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // PCM byte ports
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rx_latest_reg <= BYTE_RST;
    end else if (rx_pcm_valid_i) begin
      rx_latest_reg <= rx_pcm_byte_i;                           // [RL7]
    end
  end

  // Receive path takes either the line byte or the control-written byte
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rx_path_stb_o  <= 1'b0;
      rx_path_byte_o <= BYTE_RST;
    end else if (data_done && idx_reg == IDX_RX_PORT && rx_source_sel_o) begin
      rx_path_stb_o  <= voice_enable_o;                         // [RL7] [RL18] [RL20]
      rx_path_byte_o <= shift_byte;
    end else if (rx_pcm_valid_i && !rx_source_sel_o) begin
      rx_path_stb_o  <= voice_enable_o;
      rx_path_byte_o <= rx_pcm_byte_i;
    end else begin
      rx_path_stb_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tx_port_reg <= BYTE_RST;
    end else if (data_done && idx_reg == IDX_TX_PORT) begin
      tx_port_reg <= shift_byte;                                // [RL7]
    end
  end

  // Transmit line byte is picked per frame; the port byte repeats until rewritten
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tx_line_stb_o  <= 1'b0;
      tx_line_byte_o <= BYTE_RST;
    end else begin
      tx_line_stb_o <= tx_path_valid_i && voice_enable_o;       // [RL20]
      if (tx_path_valid_i) begin
        tx_line_byte_o <= tx_source_sel_o ? tx_port_reg : tx_path_byte_i;  // [RL19]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read-back data selection
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      load_reg      <= 1'b0;
      load_byte_reg <= BYTE_RST;
    end else begin
      load_reg <= (state_reg == ST_FETCH);                      // [RL23]
      case (idx_reg)
        IDX_FRAMING: load_byte_reg <= framing_reg;
        IDX_TIMING:  load_byte_reg <= timing_reg;
        IDX_RX_PORT: load_byte_reg <= rx_latest_reg;            // [RL7]
        default:     load_byte_reg <= ext_rd_data_i;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  power_bit_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL2]
    cmd_done |=> power_down_o == $past(shift_byte[POWER_BIT]))
    else $error("power state does not follow address bit 7");

  single_byte_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL3]
    (cmd_done && !shift_byte[FOLLOW_BIT]) |=> state_reg == ST_IDLE)
    else $error("single-byte command expected a data byte");

  read_path_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL4]
    (cmd_done && shift_byte[FOLLOW_BIT] && shift_byte[DIR_BIT]) |=> state_reg != ST_WRITE)
    else $error("read command entered write state");

  hidden_idx_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL8]
    ext_wr_stb_o |-> is_writable(idx_reg) && idx_reg != IDX_TEST || idx_reg == IDX_TEST)
    else $error("write forwarded to an inaccessible index");

  no_tx_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL5]
    (cmd_done && shift_byte[FOLLOW_BIT] && shift_byte[DIR_BIT] && cmd_index == IDX_TX_PORT)
      |=> state_reg == ST_SKIP)
    else $error("transmit port was read back");

  framing_load_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL24]
    (data_done && idx_reg == IDX_FRAMING) |=> framing_reg == $past(shift_byte))
    else $error("framing register not loaded at end of data byte");

  latch_inv_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL17]
    (data_done && idx_reg == IDX_TIMING) |=> output_latch_o != $past(shift_byte[TM_LATCH]))
    else $error("output latch not inverted from timing bit 5");

  reset_zero_a: assert property (@(posedge sys_clk_i)  // [RL26]
    !reset_n_i |=> framing_reg == FRAMING_RST && timing_reg == TIMING_RST)
    else $error("configuration registers not zero after reset");

  reply_hiz_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL25]
    pins_sync[2] |-> !serial_reply_out_oe_o)
    else $error("reply output driven with chip select high");

  read_load_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL7]
    (state_reg == ST_FETCH && idx_reg == IDX_RX_PORT) |=> load_reg && load_byte_reg == $past(rx_latest_reg))
    else $error("receive port read does not return latest line byte");

  linear_gate_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)  // [RL18]
    !companding_sel_o |-> !rx_source_sel_o && !tx_source_sel_o && !channel_pick_o)
    else $error("companded-only selection active in linear mode");

  write_cov: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    data_done && idx_reg == IDX_TIMING);
  read_cov: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg == ST_READ && byte_done);
  single_cov: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    cmd_done && !shift_byte[FOLLOW_BIT] && shift_byte[POWER_BIT]);
  fwd_cov: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ext_wr_stb_o && ext_index_o == IDX_TEST);

endmodule

// File: rtl/ccd_pkg.sv
/*
 * Constants for the serial control-port register decoder of the codec.
 * Assumes a 100 MHz system clock and a host that drives the control port.
 */
package ccd_pkg;

  // ----------------------------------------------------------------------
  // Address byte fields
  // ----------------------------------------------------------------------
  localparam int unsigned POWER_BIT  = 7;
  localparam int unsigned INDEX_HI   = 6;
  localparam int unsigned INDEX_LO   = 3;
  localparam int unsigned DIR_BIT    = 2;
  localparam int unsigned FOLLOW_BIT = 1;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_FRAMING  = 4'h0;
  localparam logic [3:0] IDX_TIMING   = 4'h1;
  localparam logic [3:0] IDX_RX_PORT  = 4'h2;
  localparam logic [3:0] IDX_TX_PORT  = 4'h3;
  localparam logic [3:0] IDX_LAST_STD = 4'hb;
  localparam logic [3:0] IDX_TEST     = 4'he;

  // ----------------------------------------------------------------------
  // Framing / timing field positions
  // ----------------------------------------------------------------------
  localparam int unsigned FR_RATE_LO   = 6;
  localparam int unsigned FR_COMPAND   = 5;
  localparam int unsigned FR_FMT_LO    = 3;
  localparam int unsigned FR_SPACING   = 2;
  localparam int unsigned FR_WIDTH     = 1;
  localparam int unsigned FR_LOOPBACK  = 0;
  localparam int unsigned TM_FRAME_LO  = 6;
  localparam int unsigned TM_LATCH     = 5;
  localparam int unsigned TM_RX_SRC    = 4;
  localparam int unsigned TM_TX_SRC    = 3;
  localparam int unsigned TM_VOICE_EN  = 2;
  localparam int unsigned TM_CHANNEL   = 1;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] FRAMING_RST    = 8'h00;
  localparam logic [7:0] TIMING_RST     = 8'h00;
  localparam logic [7:0] BYTE_RST       = 8'h00;
  localparam logic       POWER_DOWN_RST = 1'b1;
  localparam logic [2:0] PINS_RST       = 3'h4;
  localparam logic [2:0] BITS_PER_BYTE  = 3'h7;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WRITE = 5'b00010,
    ST_FETCH = 5'b00100,
    ST_READ  = 5'b01000,
    ST_SKIP  = 5'b10000
  } ccd_state_t;

endpackage

// File: rtl/ccd_sync.sv
/*
 * Two-flop synchroniser for a bundle of independent pin levels.
 * Assumes each bit is a slow level; no bus coherence is implied.
 */
`timescale 1ns/1ps
module ccd_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage is read by the second stage only
  always_ff @(posedge sys_clk_i) begin
    meta_reg <= async_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      // Idle pin levels, so no false select or clock edge follows reset
      sync_o <= rst_val_i;
    end else begin
      sync_o <= meta_reg;
    end
  end

endmodule

// File: rtl/ccd_shifter.sv
/*
 * Byte shifter of the control port: MSB first in on rising control-clock
 * edges, MSB first out on falling edges. Edges arrive as sys_clk pulses.
 */
`timescale 1ns/1ps
module ccd_shifter
  import ccd_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       cs_active_i,
  input  wire logic       rise_i,
  input  wire logic       fall_i,
  input  wire logic       data_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_byte_i,
  output logic      [7:0] byte_o,
  output logic            byte_done_o,
  output logic            reply_bit_o
);

  logic [2:0] bit_cnt_reg;
  logic [7:0] out_shreg;

  // A partial byte is dropped when chip select goes away
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !cs_active_i) begin
      bit_cnt_reg <= '0;
      byte_done_o <= 1'b0;
    end else begin
      byte_done_o <= rise_i && (bit_cnt_reg == BITS_PER_BYTE);
      if (rise_i) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      byte_o <= BYTE_RST;
    end else if (cs_active_i && rise_i) begin
      byte_o <= {byte_o[6:0], data_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      out_shreg   <= BYTE_RST;
      reply_bit_o <= 1'b0;
    end else if (load_i) begin
      out_shreg <= load_byte_i;
    end else if (fall_i) begin
      reply_bit_o <= out_shreg[7];
      out_shreg   <= {out_shreg[6:0], 1'b0};
    end
  end

endmodule

// File: sim/ccd_host.sv
/*
 * Host model of the serial control port: chip select, shift clock, command.
 * Assumes a 160 ns control clock period, unrelated in phase to sys_clk.
 */
`timescale 1ns/1ps
module ccd_host (
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      cmd_o,
  input  wire logic reply_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    cmd_o  = 1'b0;
  end
  // ----------------------------------------------------------------------
  // One byte, MSB first, eight pulses; reply sampled at each rise
  // ----------------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      cmd_o = tx[i];
      #80 sclk_o = 1'b1;
      rx[i] = reply_i;
      #80 sclk_o = 1'b0;
    end
    // Released line shows the inverse so a stale bit cannot pass
    cmd_o = ~tx[0];
  endtask
  // Clock stands low while select changes
  task automatic select(input logic on);
    cs_n_o = ~on;
    #100;
  endtask
endmodule

// File: sim/codec_control_register_decoder_tb.sv
/*
 * Self-checking bench of the control-port decoder with a host model.
 * Assumes the package field constants and the hand-over timing.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module codec_control_register_decoder_tb;
  import ccd_pkg::*;
  logic       sys_clk_i, reset_n_i, rx_v, tx_v, reply_last;
  logic [7:0] rx_b, tx_b, rd, fr, tm, d, cap_rx, cap_wd;
  logic [3:0] cap_wi;
  int         fails, total_checks, n_wr, n_rx, k;
  logic [31:0] lf;
  wire        cs_n, sclk, cmd, reply, oe, pd, cmp, spc, wid, lpb, lat, rxs, txs, ven, chn, rstb, tstb, wstb;
  wire [1:0]  rate, fmt, ftm;
  wire [7:0]  rpb, tlb, wdat;
  wire [3:0]  widx;
  wire [7:0]  rdd = {~widx, widx};
  wire        reply_w = oe ? reply : ~reply_last;
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  ccd_host host (.cs_n_o(cs_n), .sclk_o(sclk), .cmd_o(cmd), .reply_i(reply_w));
  ccd_decoder DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .ctrl_shift_clock_i(sclk),
    .serial_cmd_in_i(cmd), .serial_reply_out_o(reply), .serial_reply_out_oe_o(oe), .power_down_o(pd),
    .clock_rate_o(rate), .companding_sel_o(cmp), .format_sel_o(fmt), .slot_spacing_sel_o(spc),
    .slot_width_sel_o(wid), .loopback_sel_o(lpb), .frame_timing_o(ftm), .output_latch_o(lat),
    .rx_source_sel_o(rxs), .tx_source_sel_o(txs), .voice_enable_o(ven), .channel_pick_o(chn),
    .rx_pcm_valid_i(rx_v), .rx_pcm_byte_i(rx_b), .rx_path_stb_o(rstb), .rx_path_byte_o(rpb),
    .tx_path_valid_i(tx_v), .tx_path_byte_i(tx_b), .tx_line_stb_o(tstb), .tx_line_byte_o(tlb),
    .ext_wr_stb_o(wstb), .ext_index_o(widx), .ext_wr_data_o(wdat), .ext_rd_data_i(rdd));
  always @(posedge sys_clk_i) begin
    if (oe) reply_last <= reply;
    if (wstb === 1'b1) begin
      n_wr++;
      cap_wi <= widx;
      cap_wd <= wdat;
    end
    if (rstb === 1'b1) begin
      n_rx++;
      cap_rx <= rpb;
    end
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  function automatic logic [7:0] adr(input logic p, input logic [3:0] idx, input logic rdn);
    return {p, idx, rdn, 1'b1, 1'b0};
  endfunction
  task automatic ins(input logic [7:0] a, input logic [7:0] dat, input logic split, output logic [7:0] r);
    logic [7:0] dummy;
    host.select(1'b1);
    host.xfer(a, dummy);
    if (split) begin
      host.select(1'b0);
      host.select(1'b1);
    end
    if (a[FOLLOW_BIT]) host.xfer(dat, r);
    host.select(1'b0);
  endtask
  task automatic pcm(input logic is_tx, input logic [7:0] b);
    @(negedge sys_clk_i);
    if (is_tx) begin
      tx_v = 1'b1;
      tx_b = b;
    end else begin
      rx_v = 1'b1;
      rx_b = b;
    end
    @(negedge sys_clk_i);
    rx_v = 1'b0;
    tx_v = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #500us fails++;
    finish_test();
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {fails, total_checks, n_wr, n_rx} = '0;
    lf = 32'd85986;
    {reset_n_i, rx_v, tx_v, reply_last, rx_b, tx_b} = '0;
    repeat (4) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    @(negedge sys_clk_i);
    `CHK({pd, oe, rate, cmp, fmt, ftm, lat, ven}, 11'h402)
    for (int i = 0; i < 6; i++) begin
      fr = rnd();
      fr[5] = i[0];
      ins(adr(i[1], IDX_FRAMING, 1'b0), fr, i[2], rd);
      `CHK({rate, cmp, fmt, lpb}, {fr[7:3], fr[0]})
      `CHK({spc, wid}, fr[2:1] & {2{fr[5]}})
      `CHK(pd, i[1])
      ins(adr(1'b0, IDX_FRAMING, 1'b1), 8'h00, i[0], rd);
      `CHK(rd, fr)
    end
    for (int i = 0; i < 6; i++) begin
      tm = rnd() & 8'hfe;
      ins(adr(1'b0, IDX_TIMING, 1'b0), tm, i[0], rd);
      `CHK({ftm, lat, ven}, {tm[7:6], ~tm[5], tm[2]})
      `CHK({rxs, txs, chn}, {tm[4:3], tm[1]} & {3{fr[5]}})
      ins(adr(1'b0, IDX_TIMING, 1'b1), 8'h00, 1'b0, rd);
      `CHK(rd, tm)
    end
    $display("test framing and timing done");
    for (int i = 4; i < 16; i++) begin
      k = n_wr;
      d = (i == 14) ? 8'h00 : rnd();
      ins(adr(1'b0, i[3:0], 1'b0), d, 1'b0, rd);
      if (i inside {12, 13, 15}) `CHK(n_wr, k)
      else `CHK({n_wr, cap_wi, cap_wd}, {k + 1, i[3:0], d})
      if (i < 12) begin
        ins(adr(1'b0, i[3:0], 1'b1), 8'h00, 1'b1, rd);
        `CHK(rd, {~i[3:0], i[3:0]})
      end
    end
    k = n_wr;
    ins(8'h80, 8'h00, 1'b0, rd);
    `CHK({pd, n_wr, rate}, {1'b1, k, fr[7:6]})
    ins(8'h00, 8'h00, 1'b0, rd);
    `CHK(pd, 1'b0)
    $display("test index map done");
    ins(adr(1'b0, IDX_FRAMING, 1'b0), 8'h20, 1'b0, rd);
    ins(adr(1'b0, IDX_TIMING, 1'b0), 8'h04, 1'b0, rd);
    d = rnd();
    pcm(1'b0, d);
    `CHK({rstb, rpb}, {1'b1, d})
    ins(adr(1'b0, IDX_RX_PORT, 1'b1), 8'h00, 1'b0, rd);
    `CHK(rd, d)
    ins(adr(1'b0, IDX_TIMING, 1'b0), 8'h1c, 1'b0, rd);
    k = n_rx;
    d = rnd();
    ins(adr(1'b0, IDX_RX_PORT, 1'b0), d, 1'b1, rd);
    `CHK({n_rx, cap_rx}, {k + 1, d})
    d = rnd();
    ins(adr(1'b0, IDX_TX_PORT, 1'b0), d, 1'b0, rd);
    pcm(1'b1, rnd());
    `CHK({tstb, tlb}, {1'b1, d})
    ins(adr(1'b0, IDX_TIMING, 1'b0), 8'h14, 1'b0, rd);
    pcm(1'b1, rnd());
    `CHK({tstb, tlb}, {1'b1, tx_b})
    $display("test pcm access done");
    finish_test();
  end
endmodule
